// *** logic/reset_and_interrupt_control.sv ***
// Reset initial state, NMI sources, maskable gating and accept/return sequencing
// Assumes a CPU core that pulses instr_boundary and return_from_irq_instr_exec, and a stack/memory
// port that completes each operation in the same cycle it is issued
// Function
// [RULE_01] Power-on: pin in reset mode, status cleared
// [RULE_02] Power-on: watchdog runs in watchdog mode
// [RULE_03] Leaving reset, load counter from reset vector
// [RULE_04] Chain position fixes priority, nearest wins
// [RULE_05] NMIs ignore global enable, own enable only
// [RULE_06] NMI accept clears all NMI enables, vectors
// [RULE_07] NMI request ORs three enabled sources
// [RULE_08] Reset-mode pin low holds CPU reset
// [RULE_09] Selected pin edge sets flag, enable requests
// [RULE_10] Power-up clear returns pin to reset mode
// [RULE_11] Edge-select toggle in NMI mode may trigger
// [RULE_12] Flash violation sets flag, requests if enabled
// [RULE_13] Oscillator fault sets flag, requests if enabled
// [RULE_14] Power-up clear forces LF mode, second off
// [RULE_15] Maskable sources gated individually and globally
// [RULE_16] Maskable request needs flag, enable, global
// [RULE_17] Acceptance takes exactly six cycles
// [RULE_18] Finish instruction, push counter, push status, select
// [RULE_19] Single-source flags clear on acceptance
// [RULE_20] Acceptance clears status, loads vector
// [RULE_21] Return takes five cycles, pops status then counter
// [RULE_22] Global enable in handler allows pre-emption
// [RULE_23] Synchronise inputs, sample at instruction boundaries
`timescale 1ns/1ps
`include "reset_irq_consts.svh"
module reset_and_interrupt_control #(
  parameter int                        NUM_MASKABLE     = `NUM_MASKABLE,
  parameter logic [`NUM_MASKABLE-1:0]  SINGLE_SOURCE    = 14'h3fff
) (
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  input  wire logic                          power_on_reset,
  input  wire logic                          power_up_clear,
  input  wire logic                          reset_nmi_pin,
  input  wire logic                          nmi_mode_select,
  input  wire logic                          nmi_edge_select,
  input  wire logic                          osc_fault_event,
  input  wire logic                          flash_violation_event,
  input  wire reset_irq_pkg::nmi_enables_t   nmi_enable_set,
  input  wire reset_irq_pkg::nmi_flags_t     nmi_flag_clear,
  input  wire logic [NUM_MASKABLE-1:0]       periph_flag,
  input  wire logic [NUM_MASKABLE-1:0]       periph_enable,
  input  wire logic                          instr_boundary,
  input  wire logic                          return_from_irq_instr_exec,
  input  wire logic                          status_write,
  input  wire logic [15:0]                   status_wdata,
  input  wire logic [15:0]                   mem_rdata,
  input  wire logic [15:0]                   next_instr_addr,
  output logic                               cpu_reset,
  output logic                               pin_is_reset_mode,
  output logic                               watchdog_mode,
  output logic                               watchdog_run,
  output logic                               lf_crystal_lf_mode,
  output logic                               second_osc_off,
  output reset_irq_pkg::nmi_enables_t        nmi_enables,
  output reset_irq_pkg::nmi_flags_t          nmi_flags,
  output logic [NUM_MASKABLE-1:0]            periph_flag_clear,
  output logic [15:0]                        cpu_status_word,
  output logic [15:0]                        program_counter,
  output logic                               global_irq_enable,
  output reset_irq_pkg::stack_ops_t          stack_ops,
  output logic [15:0]                        mem_addr,
  output logic [15:0]                        stack_wdata,
  output logic                               busy
);
  localparam int WIDX = $clog2(NUM_MASKABLE);

  // Vector address for a maskable chain position
  function automatic logic [15:0] vector_of(input logic [WIDX-1:0] idx);
    vector_of = `VECTOR_TABLE_BASE + {11'h000, idx, 1'b0};
  endfunction

  // Two-stage synchronisers; stage one is read only by stage two
  logic [2:0]               sync_a;
  logic [2:0]               sync_b;
  logic [NUM_MASKABLE-1:0]  pf_a;
  logic [NUM_MASKABLE-1:0]  pf_b;
  logic                     pin_prev;
  logic                     edge_prev;
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
      pf_a   <= '0;
      pf_b   <= '0;
    end else begin
      sync_a <= {reset_nmi_pin, osc_fault_event, flash_violation_event}; // [RULE_23]
      sync_b <= sync_a; // [RULE_23]
      pf_a   <= periph_flag; // [RULE_23]
      pf_b   <= pf_a; // [RULE_23]
    end
  end
  wire pin_s   = sync_b[2];
  wire osc_s   = sync_b[1];
  wire flash_s = sync_b[0];

  // Pin mode, watchdog mode and oscillator state with their next values
  logic next_pin_reset_mode;
  logic next_wd_mode;
  logic next_lf_mode;
  logic next_osc2_off;
  logic next_pin_prev;
  logic next_edge_prev;
  always_comb begin
    next_pin_reset_mode = !nmi_mode_select;
    next_wd_mode        = watchdog_mode;
    next_lf_mode        = lf_crystal_lf_mode;
    next_osc2_off       = second_osc_off;
    next_pin_prev       = pin_s;
    next_edge_prev      = nmi_edge_select;
    if (power_up_clear || power_on_reset) begin
      next_pin_reset_mode = 1'b1; // [RULE_10]
      next_lf_mode        = 1'b1; // [RULE_14]
      next_osc2_off       = 1'b1; // [RULE_14]
    end
    if (power_on_reset) begin
      next_wd_mode = 1'b1; // [RULE_02]
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      pin_is_reset_mode  <= 1'b1; // [RULE_01]
      watchdog_mode      <= 1'b1; // [RULE_02]
      lf_crystal_lf_mode <= 1'b1;
      second_osc_off     <= 1'b1;
      pin_prev           <= 1'b1;
      edge_prev          <= 1'b0;
    end else begin
      pin_is_reset_mode  <= next_pin_reset_mode;
      watchdog_mode      <= next_wd_mode;
      lf_crystal_lf_mode <= next_lf_mode;
      second_osc_off     <= next_osc2_off;
      pin_prev           <= next_pin_prev;
      edge_prev          <= next_edge_prev;
    end
  end
  assign watchdog_run = 1'b1; // [RULE_02]

  // Edge detect compares the select against pin history, so a select change
  // while in NMI mode can look like an edge; in reset mode nothing fires
  wire rise_seen = !pin_prev && pin_s;
  wire fall_seen = pin_prev && !pin_s;
  wire sel_flip  = (edge_prev != nmi_edge_select) && (nmi_edge_select ? !pin_s : pin_s);
  wire pin_edge  = !pin_is_reset_mode &&
                   ((nmi_edge_select ? fall_seen : rise_seen) || sel_flip); // [RULE_09] [RULE_11]

  // NMI flags and enables; a flag set in the clearing cycle wins, but the NMI accept clear beats an enable set
  reset_irq_pkg::nmi_flags_t   next_flags;
  reset_irq_pkg::nmi_enables_t next_enables;
  logic                        nmi_taken;
  always_comb begin
    next_flags   = nmi_flags & ~nmi_flag_clear;
    next_enables = nmi_enables | nmi_enable_set;
    if (pin_edge) begin
      next_flags.pin_nmi_flag = 1'b1; // [RULE_09]
    end
    if (osc_s) begin
      next_flags.osc_fault_flag = 1'b1; // [RULE_13]
    end
    if (flash_s) begin
      next_flags.flash_violation_flag = 1'b1; // [RULE_12]
    end
    if (nmi_taken) begin
      next_enables = '0; // [RULE_06]
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      nmi_flags   <= '0;
      nmi_enables <= '0;
    end else begin
      nmi_flags   <= next_flags;
      nmi_enables <= next_enables;
    end
  end

  // Request gating: NMI sources skip the global enable
  wire nmi_req = (nmi_flags.pin_nmi_flag         && nmi_enables.pin_nmi_enable) ||
                 (nmi_flags.osc_fault_flag       && nmi_enables.osc_fault_irq_enable) ||
                 (nmi_flags.flash_violation_flag && nmi_enables.flash_violation_irq_enable); // [RULE_05] [RULE_07]
  wire [NUM_MASKABLE-1:0] mask_req = pf_b & periph_enable & {NUM_MASKABLE{global_irq_enable}}; // [RULE_15] [RULE_16]
  logic            mask_any;
  logic [WIDX-1:0] mask_win;
  irq_priority_chain #(
    .N       (NUM_MASKABLE)
  ) u_chain (
    .req     (mask_req),
    .any_req (mask_any),
    .winner  (mask_win)
  );

  // Sequencer: reset fetch, 6-cycle accept, 5-cycle return
  reset_irq_pkg::seq_state_t state;
  reset_irq_pkg::seq_state_t next_state;
  logic [2:0]                cnt;
  logic [2:0]                next_cnt;
  logic [15:0]               next_pc;
  logic [15:0]               next_status;
  logic                      sel_nmi;
  logic                      next_sel_nmi;
  logic [WIDX-1:0]           sel_idx;
  logic [WIDX-1:0]           next_sel_idx;
  logic                      hold_reset;
  always_comb begin
    hold_reset        = power_on_reset || power_up_clear || (pin_is_reset_mode && !pin_s); // [RULE_08]
    next_state        = state;
    next_cnt          = cnt;
    next_pc           = program_counter;
    next_status       = cpu_status_word;
    next_sel_nmi      = sel_nmi;
    next_sel_idx      = sel_idx;
    nmi_taken         = 1'b0;
    periph_flag_clear = '0;
    stack_ops         = '0;
    mem_addr          = 16'h0000;
    stack_wdata       = 16'h0000;
    if (status_write) begin
      next_status = status_wdata; // [RULE_22]
    end
    case (state)
      reset_irq_pkg::SEQ_FETCH_RESET: begin
        mem_addr          = `RESET_VECTOR_ADDR;
        stack_ops.load_pc = 1'b1;
        next_pc           = mem_rdata; // [RULE_03]
        next_state        = reset_irq_pkg::SEQ_IDLE;
      end
      reset_irq_pkg::SEQ_IDLE: begin
        if (instr_boundary && return_from_irq_instr_exec) begin
          next_state = reset_irq_pkg::SEQ_RETURN;
          next_cnt   = 3'd0;
        end else if (instr_boundary && (nmi_req || mask_any)) begin // [RULE_23]
          next_state   = reset_irq_pkg::SEQ_ACCEPT;
          next_cnt     = 3'd0;
          next_sel_nmi = nmi_req; // [RULE_04]
          next_sel_idx = mask_win;
        end
      end
      reset_irq_pkg::SEQ_ACCEPT: begin
        next_cnt = cnt + 3'd1;
        case (cnt)
          3'd0: begin
            stack_ops.push_pc = 1'b1; // [RULE_18]
            stack_wdata       = next_instr_addr;
          end
          3'd1: begin
            stack_ops.push_status = 1'b1; // [RULE_18]
            stack_wdata           = cpu_status_word;
          end
          3'd2: begin
            if (sel_nmi) begin
              nmi_taken = 1'b1; // [RULE_06]
            end else if (SINGLE_SOURCE[sel_idx]) begin
              periph_flag_clear[sel_idx] = 1'b1; // [RULE_19]
            end
          end
          3'd3: begin
            next_status = `STATUS_RESET_VALUE; // [RULE_20]
          end
          3'd4: begin
            mem_addr          = sel_nmi ? `NMI_VECTOR_ADDR : vector_of(sel_idx); // [RULE_06]
            stack_ops.load_pc = 1'b1;
            next_pc           = mem_rdata; // [RULE_20]
          end
          default: begin
            next_state = reset_irq_pkg::SEQ_IDLE; // [RULE_17]
          end
        endcase
      end
      reset_irq_pkg::SEQ_RETURN: begin
        next_cnt = cnt + 3'd1;
        case (cnt)
          3'd1: begin
            stack_ops.pop_status = 1'b1;
            next_status          = mem_rdata; // [RULE_21]
          end
          3'd3: begin
            stack_ops.pop_pc = 1'b1;
            next_pc          = mem_rdata; // [RULE_21]
          end
          3'd4: begin
            next_state = reset_irq_pkg::SEQ_IDLE; // [RULE_21]
          end
          default: begin
          end
        endcase
      end
      default: begin
        next_state = reset_irq_pkg::SEQ_IDLE;
      end
    endcase
    // Any reset source aborts the sequence and refetches the vector
    if (hold_reset) begin
      next_state  = reset_irq_pkg::SEQ_FETCH_RESET;
      next_status = `STATUS_RESET_VALUE; // [RULE_01]
      next_cnt    = 3'd0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state           <= reset_irq_pkg::SEQ_FETCH_RESET;
      cnt             <= 3'd0;
      program_counter <= 16'h0000;
      cpu_status_word <= `STATUS_RESET_VALUE; // [RULE_01]
      sel_nmi         <= 1'b0;
      sel_idx         <= '0;
      cpu_reset       <= 1'b1;
    end else begin
      state           <= next_state;
      cnt             <= next_cnt;
      program_counter <= next_pc;
      cpu_status_word <= next_status;
      sel_nmi         <= next_sel_nmi;
      sel_idx         <= next_sel_idx;
      cpu_reset       <= hold_reset; // [RULE_08]
    end
  end

  // Global enable lives in the status word; nesting follows from it
  assign global_irq_enable = cpu_status_word[`STATUS_GIE_BIT]; // [RULE_22]
  assign busy = (state != reset_irq_pkg::SEQ_IDLE);
endmodule // reset_and_interrupt_control

// *** logic/reset_irq_consts.svh ***
// Offsets, vector addresses, field positions, reset values and timing counts
// Included by the package and the controller module; definitions only
`ifndef RESET_IRQ_CONSTS_SVH
`define RESET_IRQ_CONSTS_SVH
`define RESET_VECTOR_ADDR   16'hfffe
`define NMI_VECTOR_ADDR     16'hfffc
`define VECTOR_TABLE_BASE   16'hffe0
`define STATUS_RESET_VALUE  16'h0000
`define STATUS_GIE_BIT      3
`define ACCEPT_CYCLES       6
`define RETURN_CYCLES       5
`define NUM_MASKABLE        14
`endif

// *** logic/reset_irq_pkg.sv ***
// Types shared by the reset and interrupt controller files
// Assumes reset_irq_consts.svh is on the include path
`include "reset_irq_consts.svh"
package reset_irq_pkg;
  typedef enum logic [2:0] {
    SEQ_IDLE,
    SEQ_FETCH_RESET,
    SEQ_ACCEPT,
    SEQ_RETURN
  } seq_state_t;

  typedef struct packed {
    logic pin_nmi_enable;
    logic osc_fault_irq_enable;
    logic flash_violation_irq_enable;
  } nmi_enables_t;

  typedef struct packed {
    logic pin_nmi_flag;
    logic osc_fault_flag;
    logic flash_violation_flag;
  } nmi_flags_t;

  typedef struct packed {
    logic        push_pc;
    logic        push_status;
    logic        pop_status;
    logic        pop_pc;
    logic        load_pc;
  } stack_ops_t;
endpackage

// *** logic/irq_priority_chain.sv ***
// Fixed-priority chain arbiter: the highest index is nearest the CPU
// Assumes requests are already gated and stable at instruction boundaries
`timescale 1ns/1ps
module irq_priority_chain #(
  parameter int N = 14
) (
  input  wire logic [N-1:0]         req,
  output logic                      any_req,
  output logic [$clog2(N)-1:0]      winner
);
  // Higher position wins; scan upward so the last hit is the highest
  always_comb begin
    any_req = 1'b0;
    winner  = '0;
    for (int i = 0; i < N; i++) begin
      if (req[i]) begin
        any_req = 1'b1; // [RULE_04]
        winner  = i[$clog2(N)-1:0]; // [RULE_04]
      end
    end
  end
endmodule // irq_priority_chain

// *** verif/irq_stack_mem.sv ***
// Stack and vector memory seen by the interrupt controller
// Assumes pushes and pops complete in the cycle that issues them
`timescale 1ns/1ps
module irq_stack_mem (
  input  wire logic                      clk,
  input  wire reset_irq_pkg::stack_ops_t stack_ops,
  input  wire logic [15:0]               mem_addr,
  input  wire logic [15:0]               stack_wdata,
  output logic [15:0]                    mem_rdata
);
  logic [15:0] stk [0:7];
  logic [2:0]  sp = 3'h0;
  // Push writes the top, pop frees it; return address sits under the status word
  always @(posedge clk) begin
    if (stack_ops.push_pc || stack_ops.push_status) begin
      stk[sp] <= stack_wdata;
      sp      <= sp + 3'h1;
    end else if (stack_ops.pop_status || stack_ops.pop_pc) begin
      sp <= sp - 3'h1;
    end
  end
  // Vector words carry the low byte of their own address so each vector is recognisable
  always_comb begin
    if (stack_ops.pop_status || stack_ops.pop_pc)
      mem_rdata = stk[sp - 3'h1];
    else
      mem_rdata = {8'hc0, mem_addr[7:0]};
  end
endmodule // irq_stack_mem

// *** verif/reset_and_interrupt_control_chk.sv ***
// Port-level checks of the reset and interrupt controller
// Assumes one clock domain with a synchronous active-low reset
`timescale 1ns/1ps
module reset_and_interrupt_control_chk (
  input wire logic                        clk,
  input wire logic                        rst_b,
  input wire logic                        power_on_reset,
  input wire logic                        power_up_clear,
  input wire logic                        flash_violation_event,
  input wire logic [15:0]                 mem_rdata,
  input wire logic                        pin_is_reset_mode,
  input wire logic                        watchdog_mode,
  input wire logic                        lf_crystal_lf_mode,
  input wire logic                        second_osc_off,
  input wire reset_irq_pkg::nmi_enables_t nmi_enables,
  input wire reset_irq_pkg::nmi_flags_t   nmi_flags,
  input wire logic [15:0]                 cpu_status_word,
  input wire logic [15:0]                 program_counter,
  input wire logic                        global_irq_enable,
  input wire reset_irq_pkg::stack_ops_t   stack_ops,
  input wire logic [15:0]                 mem_addr,
  input wire logic                        busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Accept pushes counter then status; return pops status then counter
  sequence s_push; stack_ops.push_pc ##1 stack_ops.push_status; endsequence
  sequence s_unstack; stack_ops.pop_status ##2 stack_ops.pop_pc; endsequence
  a_por_state: assert property (power_on_reset |=> pin_is_reset_mode && watchdog_mode && cpu_status_word == 16'h0000)
    else $error("power-on state wrong");
  a_puc_clocks: assert property (power_up_clear |=> lf_crystal_lf_mode && second_osc_off && pin_is_reset_mode)
    else $error("power-up clear state wrong");
  a_accept_steps: assert property (stack_ops.push_pc |-> s_push ##3 stack_ops.load_pc)
    else $error("accept sequence wrong");
  a_accept_idle: assert property (stack_ops.load_pc && mem_addr != 16'hfffe |-> ##[1:2] !busy)
    else $error("accept overruns");
  a_status_clear: assert property (stack_ops.load_pc |-> cpu_status_word == 16'h0000)
    else $error("status not cleared on accept");
  a_load_vector: assert property (stack_ops.load_pc |=> program_counter == $past(mem_rdata))
    else $error("counter not loaded from vector");
  a_vector_map: assert property (stack_ops.load_pc |-> mem_addr[15:5] == 11'h7ff && !mem_addr[0])
    else $error("vector outside table");
  a_nmi_disarm: assert property (stack_ops.load_pc && mem_addr == 16'hfffc |-> nmi_enables == 3'h0)
    else $error("nmi enables kept");
  a_return_steps: assert property (stack_ops.pop_status |-> s_unstack)
    else $error("return sequence wrong");
  a_status_pop: assert property (stack_ops.pop_status |=> cpu_status_word == $past(mem_rdata))
    else $error("status not restored");
  a_gie_mirror: assert property (global_irq_enable == cpu_status_word[3])
    else $error("global enable differs from status");
  // An accept taken with the global enable off can only be the NMI
  a_masked_quiet: assert property (
    stack_ops.push_pc && !$past(global_irq_enable) |-> ##4 mem_addr == 16'hfffc)
    else $error("masked source accepted with global enable off");
  a_flash_flag: assert property (flash_violation_event |-> ##[1:3] nmi_flags.flash_violation_flag)
    else $error("flash flag not set");
endmodule // reset_and_interrupt_control_chk
bind reset_and_interrupt_control reset_and_interrupt_control_chk reset_and_interrupt_control_chk_inst (.*);

// *** verif/testbench.sv ***
// Self-checking bench of the reset and interrupt controller
// Assumes the stack memory model and the checker are compiled first
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin miscompares++; \
  $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module testbench;
  logic clk = 1'b0, rst_b = 1'b0, power_on_reset = 1'b1, power_up_clear = 1'b0, reset_nmi_pin = 1'b1;
  logic nmi_mode_select = 1'b0, nmi_edge_select = 1'b0, osc_fault_event = 1'b0, flash_violation_event = 1'b0;
  logic instr_boundary = 1'b0, return_from_irq_instr_exec = 1'b0, status_write = 1'b0;
  logic [13:0] periph_flag = 14'h0, periph_enable = 14'h0, periph_flag_clear, m, e;
  logic [15:0] status_wdata = 16'h0, next_instr_addr = 16'h1234, mem_rdata, mem_addr, stack_wdata, pc0;
  logic [15:0] cpu_status_word, program_counter;
  logic cpu_reset, pin_is_reset_mode, watchdog_mode, watchdog_run, lf_crystal_lf_mode, second_osc_off;
  logic global_irq_enable, busy;
  logic [13:0] clr_seen;
  reset_irq_pkg::nmi_enables_t nmi_enable_set = 3'h0, nmi_enables;
  reset_irq_pkg::nmi_flags_t   nmi_flag_clear = 3'h0, nmi_flags;
  reset_irq_pkg::stack_ops_t   stack_ops;
  int seed = 32'h17fca067, miscompares = 0, comparisons = 0, cycles = 0;
  reset_and_interrupt_control reset_and_interrupt_control_inst (.*);
  irq_stack_mem irq_stack_mem_inst (.*);
  always #5 clk = ~clk;
  // Flag drops asked of the peripherals since the last boundary
  always @(posedge clk) begin
    if (instr_boundary)
      clr_seen <= 14'h0;
    else
      clr_seen <= clr_seen | periph_flag_clear;
  end
  // Cut a hang short
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One boundary pulse, then wait for the sequence to finish
  task automatic step(input logic return_from_irq_instr);
    int k;
    k = 0;
    instr_boundary = 1'b1;
    return_from_irq_instr_exec = return_from_irq_instr;
    tick(1);
    instr_boundary = 1'b0;
    return_from_irq_instr_exec = 1'b0;
    while (busy !== 1'b0 && k < 20) begin
      tick(1);
      k++;
    end
    `CHK(busy, 1'b0)
    tick(1);
  endtask
  task automatic write_status(input logic [15:0] v);
    status_write = 1'b1;
    status_wdata = v;
    tick(1);
    status_write = 1'b0;
  endtask
  // Highest index wins; each vector word holds the low byte of its own address
  function automatic logic [15:0] vec(input logic [13:0] r);
    vec = 16'h0000;
    for (int j = 0; j < 14; j++)
      if (r[j]) vec = 16'hc0e0 + 16'(2 * j);
  endfunction
  // One-hot of the winning source, the only flag a single-source accept drops
  function automatic logic [13:0] top_bit(input logic [13:0] r);
    top_bit = 14'h0;
    for (int j = 0; j < 14; j++)
      if (r[j]) top_bit = 14'h1 << j;
  endfunction
  initial begin
    tick(6);
    `CHK(pin_is_reset_mode, 1'b1)
    `CHK(watchdog_mode, 1'b1)
    `CHK(watchdog_run, 1'b1)
    rst_b = 1'b1;
    power_on_reset = 1'b0;
    tick(8);
    `CHK(cpu_reset, 1'b0)
    `CHK(program_counter, 16'hc0fe)
    reset_nmi_pin = 1'b0;
    tick(5);
    `CHK(cpu_reset, 1'b1)
    reset_nmi_pin = 1'b1;
    tick(8);
    `CHK(program_counter, 16'hc0fe)
    // Random maskable traffic; the first pass has every source pending
    for (int i = 0; i < 16; i++) begin
      m = (i == 0) ? 14'h3fff : 14'($random(seed));
      e = (i == 0) ? 14'h3fff : 14'($random(seed));
      write_status((i % 4 == 3) ? 16'h0000 : 16'h0008);
      periph_flag = m;
      periph_enable = e;
      next_instr_addr = 16'($random(seed)) & 16'hfffe;
      pc0 = program_counter;
      tick(3);
      step(1'b0);
      periph_flag = 14'h0;
      `CHK(clr_seen, (i % 4 == 3) ? 14'h0 : top_bit(m & e))
      if (i % 4 != 3 && (m & e) != 14'h0) begin
        `CHK(program_counter, vec(m & e))
        `CHK(global_irq_enable, 1'b0)
        step(1'b1);
        `CHK(program_counter, next_instr_addr)
        `CHK(cpu_status_word, 16'h0008)
      end else
        `CHK(program_counter, pc0)
    end
    // Pin in NMI mode, rising edge, maskable sources pending but masked
    write_status(16'h0000);
    periph_flag = 14'h3fff;
    nmi_mode_select = 1'b1;
    tick(3);
    `CHK(pin_is_reset_mode, 1'b0)
    reset_nmi_pin = 1'b0;
    tick(4);
    `CHK(nmi_flags.pin_nmi_flag, 1'b0)
    `CHK(cpu_reset, 1'b0)
    reset_nmi_pin = 1'b1;
    tick(4);
    `CHK(nmi_flags.pin_nmi_flag, 1'b1)
    pc0 = program_counter;
    step(1'b0);
    `CHK(program_counter, pc0)
    nmi_enable_set = 3'b100;
    tick(1);
    nmi_enable_set = 3'b000;
    step(1'b0);
    `CHK(program_counter, 16'hfffc & 16'hc0fc)
    `CHK(nmi_enables, 3'b000)
    `CHK(nmi_flags.pin_nmi_flag, 1'b1)
    `CHK(clr_seen, 14'h0)
    step(1'b1);
    periph_flag = 14'h0;
    flash_violation_event = 1'b1;
    tick(1);
    flash_violation_event = 1'b0;
    osc_fault_event = 1'b1;
    tick(1);
    osc_fault_event = 1'b0;
    tick(3);
    `CHK(nmi_flags.flash_violation_flag, 1'b1)
    `CHK(nmi_flags.osc_fault_flag, 1'b1)
    step(1'b0);
    `CHK(program_counter, next_instr_addr)
    nmi_enable_set = 3'b010;
    tick(1);
    nmi_enable_set = 3'b000;
    step(1'b0);
    `CHK(program_counter, 16'hc0fc)
    step(1'b1);
    // Edge select toggled outside NMI mode must stay quiet
    nmi_mode_select = 1'b0;
    nmi_flag_clear = 3'b111;
    tick(1);
    nmi_flag_clear = 3'b000;
    nmi_edge_select = 1'b1;
    tick(2);
    nmi_edge_select = 1'b0;
    tick(4);
    `CHK(nmi_flags.pin_nmi_flag, 1'b0)
    nmi_mode_select = 1'b1;
    power_up_clear = 1'b1;
    tick(2);
    `CHK(pin_is_reset_mode, 1'b1)
    `CHK(second_osc_off, 1'b1)
    power_up_clear = 1'b0;
    tick(8);
    `CHK(program_counter, 16'hc0fe)
    // Mid-run power-on reset with the global enable set beforehand
    write_status(16'h0008);
    power_on_reset = 1'b1;
    tick(2);
    `CHK(cpu_reset, 1'b1)
    `CHK(cpu_status_word, 16'h0000)
    `CHK(pin_is_reset_mode, 1'b1)
    `CHK(watchdog_mode, 1'b1)
    power_on_reset = 1'b0;
    tick(8);
    `CHK(cpu_reset, 1'b0)
    `CHK(program_counter, 16'hc0fe)
    end_sim();
  end
endmodule // testbench
